// ===== common/clock_select_defs.svh
`ifndef CLOCK_SELECT_DEFS_SVH
`define CLOCK_SELECT_DEFS_SVH

// ****************************************************************
// Register offsets (word index on the command port)
// ****************************************************************
`define CS_ADDR_CTRL    3'h0
`define CS_ADDR_FREQ    3'h1
`define CS_ADDR_DIV     3'h2
`define CS_ADDR_STATUS  3'h3
`define CS_ADDR_MASK    3'h4
`define CS_ADDR_SMBADDR 3'h5
`define CS_ADDR_VOUT    3'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define CS_CTRL_SYNC_OUT   0
`define CS_CTRL_EXT_SEL    1
`define CS_ST_EXT_FAULT    0
`define CS_ST_EXT_LOCK     1
`define CS_DIV_BUSY        15

// ****************************************************************
// Reset values
// ****************************************************************
`define CS_CTRL_RST   2'h0
`define CS_MASK_RST   2'h0
`define CS_FREQ_RST   16'h01f4

// ****************************************************************
// Frequency and divisor limits
// ****************************************************************
`define CS_REF_KHZ    32'd30000
`define CS_DIV_MIN    8'd30
`define CS_DIV_MAX    8'd150
`define CS_FREQ_MIN   16'd200
`define CS_FREQ_MAX   16'd1000
`define CS_SMB_BASE   7'h60
`define CS_OPEN_CODE  4'h5

// ****************************************************************
// Timing
// ****************************************************************
`define CS_CLK_NS     50
`define CS_LOSS_NS    10000
`define CS_LOSS_CYC   ((`CS_LOSS_NS + `CS_CLK_NS - 1) / `CS_CLK_NS)

`endif

// ===== common/clock_select_pkg.sv
package clock_select_pkg;

    // Divisor search sequencer
    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_DIV,
        CALC_PICK
    } calc_state_t;

    // Settings decoded from the straps at power-on
    typedef struct packed {
        logic [6:0]  smbus_addr;
        logic [15:0] vout_mv;
        logic [4:0]  vout_sel;
    } strap_cfg_t;

    // Sticky events
    typedef struct packed {
        logic ext_lock;
        logic ext_fault;
    } events_t;

endpackage

// ===== rtl/switching_clock_select.sv
`include "clock_select_defs.svh"

// Behaviour
// - Switching frequency 200 kHz to 1 MHz, from strap or frequency command
// - Internal clock is the 30 MHz reference divided by 30 to 150
// - A commanded frequency picks the whole divisor giving the nearest frequency
// - Sixteen frequency strap codes, 250 to 1000 kHz; open pin gives 500 kHz
// - Switching clock locks to an external clock on the sync pin as input
// - With the internal clock, optionally drive it out on the sync pin
// - External mode follows any in-range frequency, not only divisor steps
// - Lost external clock sets the external fault flag and shuts down on the same edge
// - After a clock loss the next enable runs from the internal clock
// - Sync resumes only after power-on with the external strap set, or a new external select
// - Bus address comes from the strap, 0x60 to 0x67, unique per bus
// - One strap encodes output voltage from 0.5 V and the bus address
// - All straps are read at power-on and set frequency, address, voltage, sync select
module switching_clock_select
    import clock_select_pkg::*;
#(
    parameter int LOSS_CYC = `CS_LOSS_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WRITE,
    input  wire logic        READ,
    output logic      [15:0] RDATA,
    output logic             IRQ,
    input  wire logic [3:0]  FREQ_STRAP,
    input  wire logic [7:0]  VADDR_STRAP,
    input  wire logic        SYNC_EXT_STRAP,
    input  wire logic        ENABLE,
    input  wire logic        SYNC_IN,
    output logic             SYNC_OUT,
    output logic             SYNC_OE_N,
    output logic             SW_CLK,
    output logic             RUN,
    output strap_cfg_t       STRAP_CFG
);

    // Loss counter is 12 bits and needs at least two cycles of history
    if (LOSS_CYC < 2 || LOSS_CYC > 4095) begin : g_loss_check
        $error("LOSS_CYC out of range");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int PW = 15;
    logic [PW-1:0] pin_m_q;
    logic [PW-1:0] pin_s_q;
    logic          sync_d1_q;
    logic [3:0]    freq_strap_s;
    logic [7:0]    vaddr_strap_s;
    logic          ext_strap_s;
    logic          enable_s;
    logic          sync_s;
    logic          sync_rise;

    // First stage feeds only the second
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
            sync_d1_q <= 1'b0;
        end else begin
            pin_m_q <= {SYNC_IN, ENABLE, SYNC_EXT_STRAP, VADDR_STRAP, FREQ_STRAP};
            pin_s_q <= pin_m_q;
            sync_d1_q <= pin_s_q[14];
        end
    end

    assign freq_strap_s  = pin_s_q[3:0];
    assign vaddr_strap_s = pin_s_q[11:4];
    assign ext_strap_s   = pin_s_q[12];
    assign enable_s      = pin_s_q[13];
    assign sync_s        = pin_s_q[14];
    assign sync_rise     = sync_s && !sync_d1_q;

    // ****************************************************************
    // Strap decode tables
    // ****************************************************************
    // Frequency strap code to reference divisor
    function automatic logic [7:0] strap_div(input logic [3:0] code);
        case (code)
            4'h0:    strap_div = 8'd120;
            4'h1:    strap_div = 8'd100;
            4'h2:    strap_div = 8'd85;
            4'h3:    strap_div = 8'd75;
            4'h4:    strap_div = 8'd66;
            4'h5:    strap_div = 8'd60;
            4'h6:    strap_div = 8'd55;
            4'h7:    strap_div = 8'd50;
            4'h8:    strap_div = 8'd46;
            4'h9:    strap_div = 8'd43;
            4'ha:    strap_div = 8'd40;
            4'hb:    strap_div = 8'd37;
            4'hc:    strap_div = 8'd35;
            4'hd:    strap_div = 8'd33;
            4'he:    strap_div = 8'd31;
            default: strap_div = 8'd30;
        endcase
    endfunction

    // Voltage row to millivolts; zero marks the disabled row
    function automatic logic [15:0] row_mv(input logic [4:0] row);
        logic [15:0] r;
        r = {11'h000, row};
        if (row < 5'd13) begin
            row_mv = 16'd500 + r * 16'd50;
        end else if (row == 5'd13) begin
            row_mv = 16'd1150;
        end else if (row < 5'd28) begin
            row_mv = 16'd1200 + (r - 16'd14) * 16'd100;
        end else if (row == 5'd28) begin
            row_mv = 16'd0;
        end else if (row == 5'd29) begin
            row_mv = 16'd3300;
        end else if (row == 5'd30) begin
            row_mv = 16'd4500;
        end else begin
            row_mv = 16'd5000;
        end
    endfunction

    // ****************************************************************
    // Power-on strap capture
    // ****************************************************************
    logic [1:0]  por_cnt_q;
    logic        por_take;
    strap_cfg_t  strap_q;

    // Waits out the synchroniser so the straps are settled
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            por_cnt_q <= 2'h0;
        end else if (por_cnt_q != 2'h3) begin
            por_cnt_q <= por_cnt_q + 2'h1;
        end
    end

    assign por_take = (por_cnt_q == 2'h2);

    // Address in the top three bits, voltage row below
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            strap_q <= '0;
        end else if (por_take) begin
            strap_q.smbus_addr <= `CS_SMB_BASE + {4'h0, vaddr_strap_s[7:5]};
            strap_q.vout_sel   <= vaddr_strap_s[4:0];
            strap_q.vout_mv    <= row_mv(vaddr_strap_s[4:0]);
        end
    end

    assign STRAP_CFG = strap_q;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [1:0]  ctrl_q;
    logic [1:0]  mask_q;
    logic [15:0] freq_q;
    logic        wr_ctrl;
    logic        wr_freq;
    logic [15:0] freq_clamp;

    assign wr_ctrl = WRITE && (ADDR == `CS_ADDR_CTRL);
    assign wr_freq = WRITE && (ADDR == `CS_ADDR_FREQ);

    // Out-of-range requests snap to the nearest limit
    always_comb begin
        if (WDATA < `CS_FREQ_MIN) begin
            freq_clamp = `CS_FREQ_MIN;
        end else if (WDATA > `CS_FREQ_MAX) begin
            freq_clamp = `CS_FREQ_MAX;
        end else begin
            freq_clamp = WDATA;
        end
    end

    // Control and mask words
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ctrl_q <= `CS_CTRL_RST;
            mask_q <= `CS_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= WDATA[1:0];
            end
            if (WRITE && (ADDR == `CS_ADDR_MASK)) begin
                mask_q <= WDATA[1:0];
            end
        end
    end

    // Commanded frequency, kept until power-on or a new write
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            freq_q <= `CS_FREQ_RST;
        end else if (wr_freq) begin
            freq_q <= freq_clamp;
        end
    end

    // ****************************************************************
    // Divisor search
    // ****************************************************************
    calc_state_t calc_q;
    logic [31:0] rem_q;
    logic [7:0]  n_q;
    logic [7:0]  div_q;
    logic [31:0] lhs;
    logic [31:0] rhs;
    logic [31:0] fk;
    logic [31:0] n32;
    logic [7:0]  pick;

    assign fk  = {16'h0000, freq_q};
    assign n32 = {24'h000000, n_q};
    assign lhs = `CS_REF_KHZ * (32'd2 * n32 + 32'd1);
    assign rhs = 32'd2 * fk * n32 * (n32 + 32'd1);

    // Between floor and floor+1 keep whichever frequency is nearer
    always_comb begin
        pick = (lhs <= rhs) ? n_q : n_q + 8'd1;
        if (pick < `CS_DIV_MIN) begin
            pick = `CS_DIV_MIN;
        end else if (pick > `CS_DIV_MAX) begin
            pick = `CS_DIV_MAX;
        end
    end

    // Repeated subtraction; slow but tiny, at most 150 steps
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            calc_q <= CALC_IDLE;
            rem_q  <= '0;
            n_q    <= 8'h00;
            div_q  <= `CS_DIV_MIN;
        end else if (por_take) begin
            div_q  <= strap_div(freq_strap_s);
            calc_q <= CALC_IDLE;
        end else if (wr_freq) begin
            calc_q <= CALC_DIV;
            rem_q  <= `CS_REF_KHZ;
            n_q    <= 8'h00;
        end else begin
            case (calc_q)
                CALC_IDLE: begin
                end
                CALC_DIV: begin
                    if (rem_q >= fk) begin
                        rem_q <= rem_q - fk;
                        n_q   <= n_q + 8'd1;
                    end else begin
                        calc_q <= CALC_PICK;
                    end
                end
                CALC_PICK: begin
                    div_q  <= pick;
                    calc_q <= CALC_IDLE;
                end
                default: calc_q <= CALC_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Internal switching clock
    // ****************************************************************
    logic [8:0] acc_q;
    logic [8:0] acc_add;
    logic [8:0] two_n;

    // 20 MHz steps three half-periods of 30 MHz each cycle
    assign two_n   = {div_q, 1'b0};
    assign acc_add = acc_q + 9'd3;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            acc_q <= 9'h000;
        end else if (acc_add >= two_n) begin
            acc_q <= acc_add - two_n;
        end else begin
            acc_q <= acc_add;
        end
    end

    // ****************************************************************
    // External clock follower and loss detector
    // ****************************************************************
    logic [11:0] since_q;
    logic [11:0] per_q;
    logic        per_ok_q;
    logic        ext_req_q;
    logic        ext_act_q;
    logic        lost;

    assign lost = ext_act_q && (since_q >= LOSS_CYC[11:0]);

    // Period between rising edges; saturates when the clock stops
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            since_q  <= 12'h000;
            per_q    <= 12'h000;
            per_ok_q <= 1'b0;
        end else if (sync_rise) begin
            since_q  <= 12'h001;
            per_q    <= since_q;
            per_ok_q <= (since_q != 12'h000);
        end else if (since_q != 12'hfff) begin
            since_q <= since_q + 12'h001;
        end
    end

    // Request from strap at power-on or a fresh select; loss cancels it
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ext_req_q <= 1'b0;
            ext_act_q <= 1'b0;
        end else begin
            if (por_take) begin
                ext_req_q <= ext_strap_s;
            end else if (lost) begin
                ext_req_q <= 1'b0;
            end else if (wr_ctrl && WDATA[`CS_CTRL_EXT_SEL]) begin
                ext_req_q <= 1'b1;
            end else if (wr_ctrl) begin
                ext_req_q <= 1'b0;
            end
            if (lost || !ext_req_q) begin
                ext_act_q <= 1'b0;
            end else if (sync_rise && per_ok_q) begin
                ext_act_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Fault shutdown and sticky events
    // ****************************************************************
    logic    off_q;
    events_t st_q;
    logic    lock_evt;
    logic    st_clr_wr;

    assign lock_evt  = ext_req_q && !ext_act_q && sync_rise && per_ok_q && !lost;
    assign st_clr_wr = WRITE && (ADDR == `CS_ADDR_STATUS);

    // Held off until the enable pin drops, then restart is allowed
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            off_q <= 1'b0;
        end else if (lost) begin
            off_q <= 1'b1;
        end else if (!enable_s) begin
            off_q <= 1'b0;
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            st_q <= '0;
        end else begin
            st_q.ext_fault <= lost ||
                (st_q.ext_fault && !(st_clr_wr && WDATA[`CS_ST_EXT_FAULT]));
            st_q.ext_lock <= lock_evt ||
                (st_q.ext_lock && !(st_clr_wr && WDATA[`CS_ST_EXT_LOCK]));
        end
    end

    assign IRQ = |({st_q.ext_lock, st_q.ext_fault} & mask_q);
    assign RUN = enable_s && !off_q;

    // ****************************************************************
    // Clock outputs
    // ****************************************************************
    logic sw_int;
    logic sw_ext;
    logic sw_q;
    logic so_q;
    logic oe_n_q;

    assign sw_int = (acc_q < {1'b0, div_q});
    assign sw_ext = (since_q <= {1'b0, per_q[11:1]});

    // Registered so the pins see no decode glitches
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            sw_q   <= 1'b0;
            so_q   <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            sw_q   <= RUN && (ext_act_q ? sw_ext : sw_int);
            so_q   <= sw_int;
            oe_n_q <= !(ctrl_q[`CS_CTRL_SYNC_OUT] && !ext_req_q);
        end
    end

    assign SW_CLK    = sw_q;
    assign SYNC_OUT  = so_q;
    assign SYNC_OE_N = oe_n_q;

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [15:0] rd_d;
    logic [15:0] rd_q;

    // Unmapped offsets read zero
    always_comb begin
        case (ADDR)
            `CS_ADDR_CTRL:    rd_d = {14'h0000, ctrl_q};
            `CS_ADDR_FREQ:    rd_d = freq_q;
            `CS_ADDR_DIV:     rd_d = {(calc_q != CALC_IDLE), ext_act_q, 6'h00, div_q};
            `CS_ADDR_STATUS:  rd_d = {14'h0000, st_q.ext_lock, st_q.ext_fault};
            `CS_ADDR_MASK:    rd_d = {14'h0000, mask_q};
            `CS_ADDR_SMBADDR: rd_d = {4'h0, strap_q.vout_sel, strap_q.smbus_addr};
            `CS_ADDR_VOUT:    rd_d = strap_q.vout_mv;
            default:          rd_d = 16'h0000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            rd_q <= 16'h0000;
        end else if (READ) begin
            rd_q <= rd_d;
        end else begin
            rd_q <= 16'h0000;
        end
    end

    assign RDATA = rd_q;

endmodule

// ===== testbench/sync_source_model.sv
// ********
// External sync clock source
// ********
module sync_source_model #(
    parameter int PERIOD = 41
) (
    input  wire logic clk,
    input  wire logic active,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;

    // Fixed period within 200 kHz to 1 MHz, no drift, high half >= 200 ns
    // Stands still low while inactive, like a removed clock
    initial line = 1'b0;
    always @(posedge clk) begin
        if (!active) begin
            cnt  <= 0;
            line <= 1'b0;
        end else begin
            cnt  <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            line <= (cnt < PERIOD / 2);
        end
    end
endmodule

// ===== testbench/clock_select_checker.sv
module clock_select_checker
    import clock_select_pkg::*;
#(
    parameter int LOSS_CYC = 200
) (
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic [2:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WRITE,
    input wire logic        READ,
    input wire logic [15:0] RDATA,
    input wire logic        IRQ,
    input wire logic [7:0]  VADDR_STRAP,
    input wire logic        ENABLE,
    input wire logic        SYNC_OE_N,
    input wire logic        SW_CLK,
    input wire logic        RUN,
    input wire strap_cfg_t  STRAP_CFG
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    localparam int IDLE_MAX = LOSS_CYC + 200;
    logic [15:0] idle_q;
    logic        prev_q;

    // Cycles without a switching edge while running; catches a stuck divider
    always_ff @(posedge CLOCK) begin
        prev_q <= SW_CLK;
        if (!NRST || !RUN || SW_CLK != prev_q) begin
            idle_q <= 16'h0000;
        end else begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    // ********
    // Properties
    // ********
    a_rdata_idle: assert property (!$past(READ) |-> RDATA == 16'h0000)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (READ && ADDR == 3'h7 |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_freq_echo: assert property (WRITE && ADDR == 3'h1 && WDATA >= 16'd200
        && WDATA <= 16'd1000 ##2 READ && ADDR == 3'h1 |=> RDATA == $past(WDATA, 3))
        else $error("frequency not kept");
    a_freq_clamp: assert property (WRITE && ADDR == 3'h1 && WDATA < 16'd200
        ##2 READ && ADDR == 3'h1 |=> RDATA == 16'd200)
        else $error("low frequency not clamped");
    a_div_range: assert property (READ && ADDR == 3'h2
        |=> RDATA[7:0] >= 8'd30 && RDATA[7:0] <= 8'd150)
        else $error("divisor out of range");
    a_strap_decode: assert property (STRAP_CFG != '0
        |-> STRAP_CFG.smbus_addr == {4'hc, VADDR_STRAP[7:5]}
        && STRAP_CFG.vout_sel == VADDR_STRAP[4:0])
        else $error("strap decode wrong");
    a_irq_status: assert property (READ && ADDR == 3'h3 && IRQ |=> RDATA[1:0] != 2'h0)
        else $error("interrupt without status");
    a_run_enable: assert property (RUN |-> $past(ENABLE, 2) || $past(ENABLE, 3))
        else $error("running without enable");
    a_swclk_quiet: assert property (!RUN && !$past(RUN) |-> !SW_CLK)
        else $error("switching while stopped");
    a_swclk_alive: assert property (idle_q < IDLE_MAX)
        else $error("switching clock stalled");

    c_ext_lock: cover property (READ && ADDR == 3'h3 ##1 RDATA[1]);
    c_irq_rise: cover property ($rose(IRQ));
    c_sync_drive: cover property ($fell(SYNC_OE_N));
endmodule

bind switching_clock_select clock_select_checker #(.LOSS_CYC(LOSS_CYC)) chk_u (
    .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE),
    .READ(READ), .RDATA(RDATA), .IRQ(IRQ), .VADDR_STRAP(VADDR_STRAP),
    .ENABLE(ENABLE), .SYNC_OE_N(SYNC_OE_N), .SW_CLK(SW_CLK), .RUN(RUN),
    .STRAP_CFG(STRAP_CFG)
);

// ===== testbench/tb_top.sv
`include "clock_select_defs.svh"

module tb_top
    import clock_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LOSS = 100;
    logic        CLOCK = 1'b0;
    logic        NRST = 1'b0;
    logic [2:0]  ADDR = 3'h0;
    logic [15:0] WDATA = 16'h0000;
    logic        WRITE = 1'b0;
    logic        READ = 1'b0;
    logic [3:0]  FREQ_STRAP = 4'h5;
    logic [7:0]  VADDR_STRAP = 8'h00;
    logic        ENABLE = 1'b0;
    logic        SYNC_EXT_STRAP = 1'b0;
    logic        src_on = 1'b0;
    logic        src_line;
    logic        sync_pin;
    logic [15:0] RDATA;
    logic        IRQ, SYNC_OUT, SYNC_OE_N, SW_CLK, RUN;
    strap_cfg_t  STRAP_CFG;
    int          failures = 0;
    int          check_count = 0;

    always #25 CLOCK = ~CLOCK;
    // Pin level: our drive when enabled (low), else the external source
    assign sync_pin = !SYNC_OE_N ? SYNC_OUT : src_line;

    switching_clock_select #(.LOSS_CYC(LOSS)) dut_u (
        .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE),
        .READ(READ), .RDATA(RDATA), .IRQ(IRQ), .FREQ_STRAP(FREQ_STRAP),
        .VADDR_STRAP(VADDR_STRAP), .SYNC_EXT_STRAP(SYNC_EXT_STRAP), .ENABLE(ENABLE),
        .SYNC_IN(sync_pin), .SYNC_OUT(SYNC_OUT), .SYNC_OE_N(SYNC_OE_N),
        .SW_CLK(SW_CLK), .RUN(RUN), .STRAP_CFG(STRAP_CFG)
    );
    sync_source_model #(.PERIOD(41)) src_u (.clk(CLOCK), .active(src_on), .line(src_line));

    // ********
    // Shared tasks
    // ********
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        ADDR <= a; WDATA <= d; WRITE <= 1'b1;
        @(posedge CLOCK);
        WRITE <= 1'b0;
    endtask

    // Data stand only in the cycle after the read edge
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge CLOCK);
        ADDR <= a; READ <= 1'b1;
        @(posedge CLOCK);
        READ <= 1'b0;
        @(negedge CLOCK);
        d = RDATA;
    endtask

    task automatic do_reset(input logic [3:0] f, input logic [7:0] v);
        @(posedge CLOCK);
        NRST <= 1'b0; FREQ_STRAP <= f; VADDR_STRAP <= v; ENABLE <= 1'b0;
        repeat (6) @(posedge CLOCK);
        NRST <= 1'b1;
        repeat (6) @(posedge CLOCK); // Clear of the strap capture edge
    endtask

    // Bounded wait for the divisor search to finish
    task automatic wait_search(output logic [15:0] v);
        for (int i = 0; i < 100; i++) begin
            rd(`CS_ADDR_DIV, v);
            if (v[15] === 1'b0) break;
        end
    endtask

    task automatic edges(input int cycles, output int n);
        logic p;
        p = SW_CLK;
        n = 0;
        repeat (cycles) begin
            @(negedge CLOCK);
            if (SW_CLK === 1'b1 && p === 1'b0) n++;
            p = SW_CLK;
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_straps();
        logic [3:0] code [3] = '{4'h5, 4'hf, 4'h0};
        int div [3] = '{60, 30, 120};
        logic [4:0] row [3] = '{5'd0, 5'd12, 5'd28};
        logic [2:0] idx [3] = '{3'h0, 3'h7, 3'h3};
        int mv [3] = '{500, 1100, 0};
        logic [15:0] v;
        for (int i = 0; i < 3; i++) begin
            do_reset(code[i], {idx[i], row[i]});
            rd(`CS_ADDR_DIV, v);
            chk("strap div", v & 16'h80ff, div[i]);
            rd(`CS_ADDR_SMBADDR, v);
            chk("addr reg", v, {4'h0, row[i], 4'hc, idx[i]});
            rd(`CS_ADDR_VOUT, v);
            chk("vout mv", v, mv[i]);
            chk("cfg", STRAP_CFG, {7'h60 + idx[i], 16'(mv[i]), row[i]});
            rd(`CS_ADDR_CTRL, v);
            chk("ctrl rst", v, 0);
            rd(`CS_ADDR_MASK, v);
            chk("mask rst", v, 0);
        end
    endtask

    task automatic t_freq();
        int f [5] = '{595, 100, 1000, 301, 1200};
        int rb [5] = '{595, 200, 1000, 301, 1000};
        int dv [5] = '{50, 150, 30, 100, 30};
        logic [15:0] v;
        for (int i = 0; i < 5; i++) begin
            wr(`CS_ADDR_FREQ, 16'(f[i]));
            rd(`CS_ADDR_FREQ, v);
            chk("freq", v, rb[i]);
            wait_search(v);
            chk("div", v & 16'h80ff, dv[i]);
        end
        wr(`CS_ADDR_DIV, 16'h0055);
        rd(`CS_ADDR_DIV, v);
        chk("div ro", v & 16'h00ff, 30);
        rd(3'h7, v);
        chk("unmapped", v, 0);
    endtask

    task automatic t_internal();
        logic [15:0] v;
        int n;
        wr(`CS_ADDR_FREQ, 16'd595);
        wait_search(v);
        @(posedge CLOCK);
        ENABLE <= 1'b1;
        repeat (10) @(posedge CLOCK);
        chk("run", RUN, 1);
        edges(2000, n);
        chk("int rate", n >= 59 && n <= 61, 1);
        wr(`CS_ADDR_CTRL, 16'h0001);
        repeat (3) @(posedge CLOCK);
        chk("oe on", SYNC_OE_N, 0);
        // Peers must see the very clock that drives the converter
        n = 0;
        repeat (100) begin
            @(negedge CLOCK);
            if (SYNC_OUT !== SW_CLK) n++;
        end
        chk("sync out", n, 0);
        wr(`CS_ADDR_CTRL, 16'h0000);
        repeat (3) @(posedge CLOCK);
        chk("oe off", SYNC_OE_N, 1);
    endtask

    // Select the external clock and poll status until the lock flag sets
    task automatic lock_ext();
        logic [15:0] v;
        wr(`CS_ADDR_CTRL, 16'h0002);
        for (int i = 0; i < 200; i++) begin
            rd(`CS_ADDR_STATUS, v);
            if (v[1] === 1'b1) break;
        end
        chk("lock", v[1], 1);
    endtask

    task automatic t_external();
        logic [15:0] v;
        int n;
        wr(`CS_ADDR_FREQ, 16'd480);
        wait_search(v);
        src_on <= 1'b1;
        lock_ext();
        chk("irq masked", IRQ, 0);
        wr(`CS_ADDR_MASK, 16'h0003);
        repeat (2) @(posedge CLOCK);
        chk("irq on", IRQ, 1);
        wr(`CS_ADDR_STATUS, 16'h0002);
        repeat (2) @(posedge CLOCK);
        chk("irq clr", IRQ, 0);
        edges(8200, n);
        chk("ext rate", n >= 199 && n <= 201, 1);
        src_on <= 1'b0;
        for (int i = 0; i < LOSS + 300; i++) begin
            @(posedge CLOCK);
            if (IRQ === 1'b1) break;
        end
        rd(`CS_ADDR_STATUS, v);
        chk("fault", v[0], 1);
        chk("shut", RUN, 0);
        wr(`CS_ADDR_STATUS, 16'h0001);
        repeat (2) @(posedge CLOCK);
        chk("fault clr", IRQ, 0);
        ENABLE <= 1'b0;
        repeat (5) @(posedge CLOCK);
        ENABLE <= 1'b1;
        repeat (5) @(posedge CLOCK);
        chk("rerun", RUN, 1);
        edges(2000, n);
        chk("int again", n >= 47 && n <= 49, 1);
        src_on <= 1'b1;
        repeat (500) @(posedge CLOCK);
        rd(`CS_ADDR_DIV, v);
        chk("no resync", v[14], 0);
        lock_ext();
    endtask

    // External select taken from the strap at power-on, source running
    task automatic t_strap_sync();
        logic [15:0] v;
        @(posedge CLOCK);
        SYNC_EXT_STRAP <= 1'b1;
        do_reset(4'h5, 8'h00);
        repeat (200) @(posedge CLOCK);
        rd(`CS_ADDR_DIV, v);
        chk("strap sync", v[14], 1);
    endtask

    // Watchdog, well beyond the planned run
    initial begin
        repeat (40000) @(posedge CLOCK);
        failures++;
        conclude();
    end

    initial begin
        t_straps();
        t_freq();
        t_internal();
        t_external();
        t_strap_sync();
        conclude();
    end
endmodule
